// *** hw/sif_cfg.svh ***
`ifndef SIF_CFG_SVH
`define SIF_CFG_SVH
`define SIF_OPSTAT_ADDR 8'h08
`define SIF_IRQSTAT_ADDR 8'h09
`define SIF_OPSTAT_RST 8'h00
`define SIF_IRQSTAT_RST 8'h00
`define SIF_BIT_PEND 7
`define SIF_BIT_LEVEL 6
`define SIF_BIT_FULL 5
`define SIF_BIT_EMPTY 4
`define SIF_BIT_NEW 3
`define SIF_IRQ_WAKE 2
`define SIF_IRQ_ACQ 3
`define SIF_IRQ_EMPTY 4
`define SIF_IRQ_FULL 5
`define SIF_IRQ_LEVEL 6
`define SIF_IRQ_DETECT 7
`define SIF_QUEUE_SLOTS 6'h20
`define SIF_MODE_LAG 2'h3
`endif

// *** hw/sif_pkg.sv ***
package sif_pkg;
  typedef enum logic [2:0] {
    SIF_SLEEP = 3'h0,
    SIF_STANDBY = 3'h1,
    SIF_WATCH = 3'h2,
    SIF_CONT = 3'h5,
    SIF_COMB = 3'h6,
    SIF_TRIGGERED_BURST_STATE = 3'h7
  } sif_mode_e;
endpackage

// *** hw/sif_mode_if.sv ***
interface sif_mode_if;
  logic [2:0] shown;
  logic auto_wake;
  modport lag (output shown, output auto_wake);
  modport user (input shown, input auto_wake);
endinterface

// *** hw/sif_mode_lag.sv ***
`include "sif_cfg.svh"
module sif_mode_lag (
  input wire logic clk, // core clock
  input wire logic rst_b, // async reset
  input wire logic beat, // heartbeat transition strobe
  input wire logic [2:0] cmd, // commanded mode
  input wire logic act, // activity in watch mode
  sif_mode_if.lag m // shown mode
);
  logic [1:0] cnt_q;
  logic [2:0] shown_q;
  logic wake_q;
  logic [2:0] want;
  always_comb begin
    want = cmd;
    if (cmd == 3'h3 || cmd == 3'h4) begin
      want = shown_q;
    end
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_q <= 2'h0;
      shown_q <= 3'h0;
      wake_q <= 1'b0;
    end else begin
      wake_q <= 1'b0;
      if (shown_q == 3'(sif_pkg::SIF_WATCH) && act) begin
        shown_q <= 3'(sif_pkg::SIF_CONT);
        wake_q <= 1'b1;
        cnt_q <= 2'h0;
      end else if (want == shown_q) begin
        cnt_q <= 2'h0;
      end else if (beat) begin
        if (cnt_q == `SIF_MODE_LAG - 2'h1) begin
          shown_q <= want;
          cnt_q <= 2'h0;
        end else begin
          cnt_q <= cnt_q + 2'h1;
        end
      end
    end
  end
  assign m.shown = shown_q;
  assign m.auto_wake = wake_q;
  mode_reserved_a: assert property (@(posedge clk) disable iff (!rst_b)
    shown_q != 3'h3 && shown_q != 3'h4) else $error("reserved mode");
  mode_lag_a: assert property (@(posedge clk) disable iff (!rst_b)
    (beat && want != shown_q && cnt_q == 2'h2 && !act) |=> shown_q == $past(want))
    else $error("mode did not follow");
endmodule // sif_mode_lag

// *** hw/sif_top.sv ***
`include "sif_cfg.svh"
// Notes on behaviour
// - shown mode lags command up to three beats
// - codes 000 sleep, 001 standby; 011/100 never
// - 010 watch; activity moves to continuous
// - 101 continuous, 110 combined
// - 111 triggered burst, held until command changes
// - new sample bit set until read
// - queue empty level, high after reset
// - queue full only at 32 samples
// - level bit when count reaches threshold
// - pending bit when any flag set
// - flags set only when enabled
// - clear by read or write per interface
// - wake flag on each activity-driven watch-to-continuous move
// - acquire flag in continuous/triggered only
// - empty flag rearms after non-empty
// - full flag rearms after leaving full
// - level flag when count reaches threshold
// - combined detect blocks watch until rearmed
// - rearm option rearms watch on clear of a set detect flag
module sif_top (
  input wire logic CORE_CLK, // 200 MHz
  input wire logic RST_B, // async reset, low
  input wire logic BEAT, // heartbeat transition
  input wire logic [2:0] MODE_CMD, // commanded mode
  input wire logic ACTIVITY, // watch block detects motion
  input wire logic SAMPLE_WR, // sample written to queue/outputs
  input wire logic [5:0] QUEUE_COUNT, // stored samples 0..32
  input wire logic [4:0] QUEUE_THRESH, // threshold field
  input wire logic [7:0] IRQ_ENABLE, // interrupt enables
  input wire logic SPI_SEL, // serial port is spi
  input wire logic CLEAR_BY_WRITE_SELECT, // i2c write-clear option
  input wire logic WATCH_REARM_ON_CLEAR, // rearm watch on clear
  input wire logic REG_RD, // register read strobe
  input wire logic REG_WR, // register write strobe
  input wire logic [7:0] REG_ADDR, // register address
  output logic [7:0] REG_RDATA, // read data
  output logic [7:0] OPERATING_STATUS, // status byte
  output logic [7:0] INTERRUPT_STATUS, // flag byte
  output logic WATCH_ARMED // watch block armed
);
  sif_mode_if mif ();
  sif_mode_lag u_lag (
    .clk(CORE_CLK),
    .rst_b(RST_B),
    .beat(BEAT),
    .cmd(MODE_CMD),
    .act(ACTIVITY),
    .m(mif.lag)
  );
  logic new_q, empty_q, full_q, level_q, armed_q;
  logic empty_seen_q, full_seen_q, prev_comb_q;
  logic [7:0] flag_q, set_v, clr_v, rdata_q;
  logic hit_irq, clr_now, comb, q_empty, q_full, q_level, detect;
  assign hit_irq = REG_ADDR == `SIF_IRQSTAT_ADDR;
  assign clr_now = hit_irq && ((REG_WR && (SPI_SEL || CLEAR_BY_WRITE_SELECT))
    || (REG_RD && !SPI_SEL && !CLEAR_BY_WRITE_SELECT));
  assign comb = mif.shown == 3'(sif_pkg::SIF_COMB);
  assign q_empty = QUEUE_COUNT == 6'h00;
  assign q_full = QUEUE_COUNT >= `SIF_QUEUE_SLOTS;
  assign q_level = QUEUE_COUNT >= {1'b0, QUEUE_THRESH};
  assign detect = comb && armed_q && ACTIVITY;
  always_comb begin
    set_v = 8'h00;
    set_v[`SIF_IRQ_WAKE] = mif.auto_wake;
    set_v[`SIF_IRQ_ACQ] = SAMPLE_WR && (mif.shown == 3'(sif_pkg::SIF_CONT)
      || mif.shown == 3'(sif_pkg::SIF_TRIGGERED_BURST_STATE));
    set_v[`SIF_IRQ_EMPTY] = q_empty && !empty_seen_q;
    set_v[`SIF_IRQ_FULL] = q_full && !full_seen_q;
    set_v[`SIF_IRQ_LEVEL] = q_level;
    set_v[`SIF_IRQ_DETECT] = detect;
    set_v = set_v & IRQ_ENABLE & 8'hfc;
    clr_v = clr_now ? 8'hff : 8'h00;
  end
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      flag_q <= `SIF_IRQSTAT_RST;
    end else begin
      flag_q <= (flag_q & ~clr_v) | set_v;
    end
  end
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      empty_seen_q <= 1'b0;
      full_seen_q <= 1'b0;
    end else begin
      if (!q_empty) begin
        empty_seen_q <= 1'b0;
      end else if (set_v[`SIF_IRQ_EMPTY]) begin
        empty_seen_q <= 1'b1;
      end
      if (!q_full) begin
        full_seen_q <= 1'b0;
      end else if (set_v[`SIF_IRQ_FULL]) begin
        full_seen_q <= 1'b1;
      end
    end
  end
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      armed_q <= 1'b1;
      prev_comb_q <= 1'b0;
    end else begin
      prev_comb_q <= comb;
      if (detect) begin
        armed_q <= 1'b0;
      end else if (!comb && prev_comb_q) begin
        armed_q <= 1'b1;
      end else if (clr_now && WATCH_REARM_ON_CLEAR
          && flag_q[`SIF_IRQ_DETECT]) begin
        armed_q <= 1'b1;
      end
    end
  end
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      new_q <= 1'b0;
    end else if (SAMPLE_WR) begin
      new_q <= 1'b1;
    end else if (REG_RD && REG_ADDR == `SIF_OPSTAT_ADDR) begin
      new_q <= 1'b0;
    end
  end
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      empty_q <= 1'b1;
      full_q <= 1'b0;
      level_q <= 1'b0;
    end else begin
      empty_q <= q_empty;
      full_q <= q_full;
      level_q <= q_level;
    end
  end
  logic [7:0] op_v;
  always_comb begin
    op_v = `SIF_OPSTAT_RST;
    op_v[2:0] = mif.shown;
    op_v[`SIF_BIT_NEW] = new_q;
    op_v[`SIF_BIT_EMPTY] = empty_q;
    op_v[`SIF_BIT_FULL] = full_q;
    op_v[`SIF_BIT_LEVEL] = level_q;
    op_v[`SIF_BIT_PEND] = |flag_q;
  end
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      rdata_q <= 8'h00;
    end else if (REG_RD) begin
      rdata_q <= REG_ADDR == `SIF_OPSTAT_ADDR ? op_v
        : hit_irq ? flag_q : 8'h00;
    end
  end
  assign REG_RDATA = rdata_q;
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      OPERATING_STATUS <= 8'h10;
      INTERRUPT_STATUS <= 8'h00;
      WATCH_ARMED <= 1'b1;
    end else begin
      OPERATING_STATUS <= op_v;
      INTERRUPT_STATUS <= flag_q;
      WATCH_ARMED <= armed_q;
    end
  end
  set_wins_a: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
    |set_v |=> |flag_q) else $error("set lost");
  flag_enable_a: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
    $rose(flag_q[7]) |-> $past(IRQ_ENABLE[7])) else $error("unenabled");
  pend_match_a: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
    op_v[7] == (flag_q != 8'h00)) else $error("pending wrong");
  empty_level_a: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
    q_empty |=> empty_q) else $error("empty wrong");
  full_only_a: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
    QUEUE_COUNT < 6'h20 |=> !full_q) else $error("full early");
  detect_block_a: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
    detect |=> !armed_q) else $error("watch not blocked");
  acq_mode_a: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
    $rose(flag_q[3]) |-> $past(mif.shown) inside {3'h5, 3'h7})
    else $error("acq in wrong mode");
  new_set_a: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
    SAMPLE_WR |=> new_q) else $error("new sample lost");
endmodule // sif_top

// *** verification/sif_host.sv ***
module sif_host (
  input wire logic clk, // core clock
  input wire logic [7:0] rdata, // read data
  output logic rd, // read strobe
  output logic wr, // write strobe
  output logic [7:0] addr // register address
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    rd = 1'b0;
    wr = 1'b0;
    addr = 8'h00;
  end
  // read of 0x09 is the default i2c clear
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    addr <= ~a;
    @(negedge clk);
    d = rdata;
  endtask
  // write of 0x09 is the spi or optional i2c clear
  task automatic wr_reg(input logic [7:0] a);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    @(posedge clk);
    wr <= 1'b0;
    addr <= ~a;
    @(negedge clk);
  endtask
endmodule // sif_host

// *** verification/sif_tb_top.sv ***
module sif_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic beat = 1'b0;
  logic [2:0] cmd = 3'h0;
  logic act = 1'b0;
  logic swr = 1'b0;
  logic [5:0] cnt = 6'h00;
  logic [4:0] thr = 5'h05;
  logic [7:0] en = 8'h00;
  logic spi = 1'b0;
  logic rearm = 1'b1;
  logic wsel = 1'b0;
  logic rd, wr, armed;
  logic [7:0] addr, rdata, ops, irq, d;
  int failures = 0;
  int compares = 0;
  always #2.5 clk = ~clk;
  sif_host host (.clk(clk), .rdata(rdata), .rd(rd), .wr(wr), .addr(addr));
  sif_top dut (.CORE_CLK(clk), .RST_B(rst_b), .BEAT(beat), .MODE_CMD(cmd),
    .ACTIVITY(act), .SAMPLE_WR(swr), .QUEUE_COUNT(cnt), .QUEUE_THRESH(thr),
    .IRQ_ENABLE(en), .SPI_SEL(spi), .CLEAR_BY_WRITE_SELECT(wsel),
    .WATCH_REARM_ON_CLEAR(rearm), .REG_RD(rd), .REG_WR(wr),
    .REG_ADDR(addr), .REG_RDATA(rdata), .OPERATING_STATUS(ops),
    .INTERRUPT_STATUS(irq), .WATCH_ARMED(armed));
  task automatic finish_test;
    if (failures == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e) begin
      failures++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic beats(input int n);
    repeat (n) begin
      @(posedge clk);
      beat <= 1'b1;
      @(posedge clk);
      beat <= 1'b0;
    end
    tick(2);
  endtask
  // one-cycle pulse on activity or on sample write
  task automatic hit(input bit a);
    @(posedge clk);
    if (a)
      act <= 1'b1;
    else
      swr <= 1'b1;
    @(posedge clk);
    act <= 1'b0;
    swr <= 1'b0;
    tick(2);
  endtask
  task automatic queue(input logic [5:0] c, input logic [7:0] st,
    input logic [7:0] fl);
    @(posedge clk);
    cnt <= c;
    tick(2);
    chk("queue_status", st, {ops[7:4], 4'h0});
    chk("queue_flags", fl, irq);
  endtask
  initial begin
    #100us;
    failures++;
    finish_test();
  end
  initial begin
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    tick(4);
    chk("flags_disabled", 8'h00, irq);
    host.rd_reg(8'h08, d);
    chk("opstat_reset", 8'h10, d);
    host.rd_reg(8'h0a, d);
    chk("unmapped", 8'h00, d);
    @(posedge clk);
    en <= 8'hfc;
    tick(2);
    chk("empty_flag", 8'h10, irq);
    chk("pending", 8'h01, {7'h0, ops[7]});
    host.rd_reg(8'h09, d);
    chk("read_clear", 8'h10, d);
    tick(1);
    chk("cleared", 8'h00, irq);
    chk("no_pending", 8'h00, {7'h0, ops[7]});
    queue(6'h05, 8'hc0, 8'h40);
    queue(6'h20, 8'he0, 8'h60);
    queue(6'h1f, 8'hc0, 8'h60);
    queue(6'h00, 8'h90, 8'h70);
    @(posedge clk);
    spi <= 1'b1;
    host.wr_reg(8'h09);
    tick(1);
    chk("write_clear", 8'h00, irq);
    @(posedge clk);
    cmd <= 3'h1;
    beats(2);
    chk("mode_lag", 8'h00, {5'h0, ops[2:0]});
    beats(1);
    chk("standby", 8'h01, {5'h0, ops[2:0]});
    @(posedge clk);
    cmd <= 3'h2;
    beats(3);
    chk("watch", 8'h02, {5'h0, ops[2:0]});
    hit(1'b1);
    chk("auto_cont", 8'h05, {5'h0, ops[2:0]});
    chk("wake_flag", 8'h04, irq);
    hit(1'b0);
    chk("acq_flag", 8'h0c, irq);
    host.rd_reg(8'h08, d);
    chk("new_sample", 8'h9d, d);
    tick(1);
    chk("new_cleared", 8'h00, {7'h0, ops[3]});
    host.wr_reg(8'h09);
    @(posedge clk);
    cmd <= 3'h6;
    beats(3);
    chk("combined", 8'h06, {5'h0, ops[2:0]});
    hit(1'b1);
    chk("detect_flag", 8'h80, irq);
    chk("watch_blocked", 8'h00, {7'h0, armed});
    host.wr_reg(8'h09);
    tick(1);
    chk("watch_rearmed", 8'h01, {7'h0, armed});
    @(posedge clk);
    cmd <= 3'h7;
    beats(3);
    chk("triggered", 8'h07, {5'h0, ops[2:0]});
    hit(1'b0);
    chk("triggered_burst_state_acq", 8'h08, irq);
    // sample write held across a clearing write
    @(posedge clk);
    swr <= 1'b1;
    host.wr_reg(8'h09);
    @(posedge clk);
    swr <= 1'b0;
    tick(1);
    chk("set_wins", 8'h08, irq);
    @(posedge clk);
    spi <= 1'b0;
    wsel <= 1'b1;
    host.rd_reg(8'h09, d);
    chk("wsel_read", 8'h08, d);
    tick(1);
    chk("read_kept", 8'h08, irq);
    host.wr_reg(8'h09);
    tick(1);
    chk("i2c_write_clear", 8'h00, irq);
    finish_test();
  end
endmodule // sif_tb_top
